// file: core/pcr_reader_dev.sv
// reader command interpreter: parses host frames, drives the card side
// ----------------------------------------
// What this block does
// - list code 4A answers 4B, count, target
// - 212 polling payload goes out as poll
// - exchange 40 answers 41, status, card bytes
// - exchange only to target number 01
// - host supplies full card command, length+2
// - retry detection, limit from retry input
// - poll timeout 2.42ms plus (slot+1)*1.21ms at 212, type 04 2.42ms only
// - retry while limit above 1, else none
// - exchange timeout 51.2ms, input can override
// - deselect and release answer status 00
// - type 04 lists tag, answer plus identifier
// - host sends tag command codes in exchange
// - one active target until deselected
// ----------------------------------------
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module pcr_reader_dev import pcr_pkg::*; #(
	parameter int unsigned ACT_BASE_CYC = PCR_ACT_BASE_CYC,
	parameter int unsigned ACT_SLOT_CYC = PCR_ACT_SLOT_CYC,
	parameter int unsigned EXCH_TO_CYC = PCR_EXCH_TO_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	pcr_link_if.dev l,
	output logic card_tx_valid,
	input wire logic card_tx_ready,
	output logic [7:0] card_tx_data,
	output logic card_tx_last,
	input wire logic card_rx_valid,
	output logic card_rx_ready,
	input wire logic [7:0] card_rx_data,
	input wire logic card_rx_last,
	input wire logic [7:0] activation_retry_limit,
	input wire logic [31:0] exch_timeout,
	output logic target_active
);
	typedef enum logic [3:0] {
		S_IDLE, S_LMAX, S_LBAUD, S_LPAY, S_LSEND, S_LWAIT, S_XTGT, S_XGET, S_XPUT,
		S_XWAIT, S_DRAIN, S_EMIT, S_FGET, S_FPUT
	} pcr_dst_t;

	function automatic logic [7:0] rsp_of(input logic [7:0] code);
		rsp_of = 8'(code + 8'h01);
	endfunction : rsp_of

	function automatic logic [31:0] poll_lim(input logic t1, input logic [7:0] time_slot_number);
		poll_lim = t1 ? 32'(ACT_BASE_CYC) :
			32'(ACT_BASE_CYC + (32'(time_slot_number) + 32'h1) * ACT_SLOT_CYC);
	endfunction : poll_lim

	pcr_dst_t st_q, st_d;
	logic [7:0] hdr_q [3];
	logic [7:0] hdr_d [3];
	logic [7:0] pay_q [8];
	logic [7:0] pay_d [8];
	logic [1:0] n_q, n_d;
	logic [2:0] idx_q, idx_d;
	logic [3:0] pn_q, pn_d;
	logic [7:0] tsn_q, tsn_d, rty_q, rty_d, fwd_q, fwd_d;
	logic flast_q, flast_d, fw_q, fw_d, act_q, act_d, t1_q, t1_d;
	logic [31:0] tmr_q, tmr_d, lim_q, lim_d;
	logic cmd_ready_q, cmd_ready_d, rsp_valid_q, rsp_valid_d, rsp_last_q, rsp_last_d;
	logic [7:0] rsp_data_q, rsp_data_d, tx_data_q, tx_data_d;
	logic tx_valid_q, tx_valid_d, tx_last_q, tx_last_d, rx_ready_q, rx_ready_d;
	logic take, tx_go, rx_take, rsp_go;

	assign take = l.cmd_valid & cmd_ready_q;
	assign tx_go = tx_valid_q & card_tx_ready;
	assign rx_take = card_rx_valid & rx_ready_q;
	assign rsp_go = rsp_valid_q & l.rsp_ready;

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		hdr_d = hdr_q;
		pay_d = pay_q;
		n_d = n_q;
		idx_d = (st_q == S_EMIT || st_q == S_LSEND) ? idx_q : 3'h0;
		pn_d = pn_q;
		tsn_d = tsn_q;
		rty_d = rty_q;
		fwd_d = fwd_q;
		flast_d = flast_q;
		fw_d = fw_q;
		act_d = act_q;
		t1_d = t1_q;
		tmr_d = tmr_q;
		lim_d = lim_q;
		case (st_q)
			S_IDLE: begin
				if (take) begin
					fw_d = 1'b0;
					n_d = 2'h2;
					hdr_d[0] = rsp_of(l.cmd_data);
					hdr_d[1] = PCR_ST_ERR;
					st_d = l.cmd_last ? S_EMIT : S_DRAIN;
					case (l.cmd_data)
						PCR_CMD_LIST: begin
							hdr_d[1] = PCR_NONE_FOUND;
							// a second card waits for deselect of the first
							if (!l.cmd_last && !act_q) st_d = S_LMAX;
						end
						PCR_CMD_EXCH: begin
							if (!l.cmd_last) st_d = S_XTGT;
						end
						PCR_CMD_DESEL, PCR_CMD_REL: begin
							// no card traffic, always no error
							hdr_d[1] = PCR_ST_OK;
							act_d = 1'b0;
						end
						PCR_CMD_SEL: hdr_d[1] = act_q ? PCR_ST_OK : PCR_ST_ERR;
						default: ;
					endcase
				end
			end
			S_LMAX: begin
				// only one target is ever listed, whatever the count asks
				if (take) st_d = l.cmd_last ? S_EMIT : S_LBAUD;
			end
			S_LBAUD: begin
				if (take) begin
					t1_d = (l.cmd_data == PCR_BAUD_T1);
					pay_d[0] = l.cmd_data;
					pn_d = 4'h1;
					rty_d = activation_retry_limit;
					tsn_d = 8'h00;
					if (l.cmd_data == PCR_BAUD_212 && !l.cmd_last) begin
						pn_d = 4'h0;
						st_d = S_LPAY;
					end else if (l.cmd_data == PCR_BAUD_T1 && l.cmd_last) begin
						st_d = S_LSEND;
					end else begin
						st_d = l.cmd_last ? S_EMIT : S_DRAIN;
					end
				end
			end
			S_LPAY: begin
				if (take) begin
					if (pn_q < 4'h8) begin
						pay_d[pn_q[2:0]] = l.cmd_data;
						pn_d = 4'(pn_q + 4'h1);
					end
					if (pn_q == {1'b0, PCR_TSN_POS}) tsn_d = l.cmd_data;
					if (l.cmd_last) st_d = S_LSEND;
				end
			end
			S_LSEND: begin
				if (tx_go) begin
					idx_d = 3'(idx_q + 3'h1);
					if ({1'b0, idx_q} == 4'(pn_q - 4'h1)) begin
						st_d = S_LWAIT;
						tmr_d = 32'h0;
						lim_d = poll_lim(t1_q, tsn_q);
					end
				end
			end
			S_LWAIT: begin
				if (card_rx_valid) begin
					act_d = 1'b1;
					hdr_d[0] = PCR_RSP_LIST;
					hdr_d[1] = PCR_ONE_FOUND;
					hdr_d[2] = PCR_TARGET_ONE;
					n_d = 2'h3;
					fw_d = 1'b1;
					st_d = S_EMIT;
				end else if (tmr_q >= 32'(lim_q - 32'h1)) begin
					if (rty_q == PCR_RETRY_FOREVER || rty_q > 8'h01) begin
						if (rty_q != PCR_RETRY_FOREVER) rty_d = 8'(rty_q - 8'h01);
						st_d = S_LSEND;
					end else begin
						st_d = S_EMIT; // zero found; header set at list start
					end
				end else begin
					tmr_d = 32'(tmr_q + 32'h1);
				end
			end
			S_XTGT: begin
				if (take) begin
					if (l.cmd_data == PCR_TARGET_ONE && act_q && !l.cmd_last) st_d = S_XGET;
					else st_d = l.cmd_last ? S_EMIT : S_DRAIN;
				end
			end
			S_XGET: begin
				// payload is passed raw: the host frames the card command
				if (take) begin
					fwd_d = l.cmd_data;
					flast_d = l.cmd_last;
					st_d = S_XPUT;
				end
			end
			S_XPUT: begin
				if (tx_go) begin
					st_d = flast_q ? S_XWAIT : S_XGET;
					tmr_d = 32'h0;
					lim_d = (exch_timeout == 32'h0) ? 32'(EXCH_TO_CYC) : exch_timeout;
				end
			end
			S_XWAIT: begin
				if (card_rx_valid) begin
					hdr_d[1] = PCR_ST_OK;
					fw_d = 1'b1;
					st_d = S_EMIT;
				end else if (tmr_q >= 32'(lim_q - 32'h1)) begin
					st_d = S_EMIT;
				end else begin
					tmr_d = 32'(tmr_q + 32'h1);
				end
			end
			S_DRAIN: begin
				if (take && l.cmd_last) st_d = S_EMIT;
			end
			S_EMIT: begin
				if (rsp_go) begin
					idx_d = 3'(idx_q + 3'h1);
					if (idx_q[1:0] == 2'(n_q - 2'h1)) st_d = fw_q ? S_FGET : S_IDLE;
				end
			end
			S_FGET: begin
				if (rx_take) begin
					fwd_d = card_rx_data;
					flast_d = card_rx_last;
					st_d = S_FPUT;
				end
			end
			S_FPUT: begin
				if (rsp_go) st_d = flast_q ? S_IDLE : S_FGET;
			end
			default: st_d = S_IDLE;
		endcase
	end

	// ----------------------------------------
	// registered port drive
	// ----------------------------------------
	always_comb begin
		// command intake only while idle or parsing; no overlap of commands
		cmd_ready_d = st_d inside {S_IDLE, S_LMAX, S_LBAUD, S_LPAY, S_XTGT, S_XGET, S_DRAIN};
		tx_valid_d = st_d inside {S_LSEND, S_XPUT};
		tx_data_d = (st_d == S_LSEND) ? pay_d[idx_d] : fwd_d;
		tx_last_d = (st_d == S_LSEND) ? ({1'b0, idx_d} == 4'(pn_d - 4'h1)) : flast_d;
		rx_ready_d = (st_d == S_FGET);
		rsp_valid_d = st_d inside {S_EMIT, S_FPUT};
		rsp_data_d = (st_d == S_EMIT) ? hdr_d[idx_d[1:0]] : fwd_d;
		rsp_last_d = (st_d == S_EMIT) ? (idx_d[1:0] == 2'(n_d - 2'h1) && !fw_d) : flast_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= S_IDLE;
			hdr_q <= '{default: 8'h00};
			pay_q <= '{default: 8'h00};
			n_q <= 2'h0;
			idx_q <= 3'h0;
			pn_q <= 4'h0;
			tsn_q <= 8'h00;
			rty_q <= 8'h00;
			fwd_q <= 8'h00;
			flast_q <= 1'b0;
			fw_q <= 1'b0;
			act_q <= 1'b0;
			t1_q <= 1'b0;
			tmr_q <= 32'h0;
			lim_q <= 32'h0;
			cmd_ready_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			tx_last_q <= 1'b0;
			rx_ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 8'h00;
			rsp_last_q <= 1'b0;
		end else begin
			st_q <= st_d;
			hdr_q <= hdr_d;
			pay_q <= pay_d;
			n_q <= n_d;
			idx_q <= idx_d;
			pn_q <= pn_d;
			tsn_q <= tsn_d;
			rty_q <= rty_d;
			fwd_q <= fwd_d;
			flast_q <= flast_d;
			fw_q <= fw_d;
			act_q <= act_d;
			t1_q <= t1_d;
			tmr_q <= tmr_d;
			lim_q <= lim_d;
			cmd_ready_q <= cmd_ready_d;
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
			tx_last_q <= tx_last_d;
			rx_ready_q <= rx_ready_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			rsp_last_q <= rsp_last_d;
		end
	end

	assign l.cmd_ready = cmd_ready_q;
	assign l.rsp_valid = rsp_valid_q;
	assign l.rsp_data = rsp_data_q;
	assign l.rsp_last = rsp_last_q;
	assign card_tx_valid = tx_valid_q;
	assign card_tx_data = tx_data_q;
	assign card_tx_last = tx_last_q;
	assign card_rx_ready = rx_ready_q;
	assign target_active = act_q;
endmodule : pcr_reader_dev

// file: include/pcr_pkg.sv
// constants and types shared by both ends of the reader command link
package pcr_pkg;
	// ----------------------------------------
	// command and response codes
	// ----------------------------------------
	localparam logic [7:0] PCR_CMD_LIST = 8'h4a;
	localparam logic [7:0] PCR_RSP_LIST = 8'h4b;
	localparam logic [7:0] PCR_CMD_EXCH = 8'h40;
	localparam logic [7:0] PCR_RSP_EXCH = 8'h41;
	localparam logic [7:0] PCR_CMD_SEL = 8'h54;
	localparam logic [7:0] PCR_CMD_DESEL = 8'h44;
	localparam logic [7:0] PCR_CMD_REL = 8'h52;
	localparam logic [7:0] PCR_MAX_TG = 8'h01;
	localparam logic [7:0] PCR_TARGET_ONE = 8'h01;
	localparam logic [7:0] PCR_BAUD_212 = 8'h01;
	localparam logic [7:0] PCR_BAUD_T1 = 8'h04;
	localparam logic [7:0] PCR_ST_OK = 8'h00;
	localparam logic [7:0] PCR_ST_ERR = 8'h01;
	localparam logic [7:0] PCR_NONE_FOUND = 8'h00;
	localparam logic [7:0] PCR_ONE_FOUND = 8'h01;
	localparam logic [7:0] PCR_RETRY_FOREVER = 8'hff;
	// polling payload: command, system code, request code, then slot number
	localparam logic [7:0] PCR_POLL_CMD = 8'h00;
	localparam logic [7:0] PCR_POLL_SYS = 8'hff;
	localparam logic [7:0] PCR_POLL_RC = 8'h00;
	localparam logic [2:0] PCR_TSN_POS = 3'h4;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam real PCR_CLK_HZ = 125.0e6;
	localparam real PCR_ACT_BASE_MS = 2.42;
	localparam real PCR_ACT_SLOT_MS = 1.21;
	localparam real PCR_EXCH_TO_MS = 51.2;
	localparam int unsigned PCR_ACT_BASE_CYC = int'($ceil(PCR_ACT_BASE_MS * 1.0e-3 * PCR_CLK_HZ));
	localparam int unsigned PCR_ACT_SLOT_CYC = int'($ceil(PCR_ACT_SLOT_MS * 1.0e-3 * PCR_CLK_HZ));
	localparam int unsigned PCR_EXCH_TO_CYC = int'($ceil(PCR_EXCH_TO_MS * 1.0e-3 * PCR_CLK_HZ));
	// ----------------------------------------
	// host controller registers
	// ----------------------------------------
	localparam logic [7:0] PCR_REG_CTRL = 8'h00;
	localparam logic [7:0] PCR_REG_TXDATA = 8'h04;
	localparam logic [7:0] PCR_REG_RXDATA = 8'h08;
	localparam logic [7:0] PCR_REG_STATUS = 8'h0c;
	localparam logic [7:0] PCR_REG_ISTAT = 8'h10;
	localparam logic [7:0] PCR_REG_IMASK = 8'h14;
	localparam int PCR_TX_LAST_BIT = 8;
	localparam int PCR_IRQ_DONE = 0;
	localparam int PCR_IRQ_RXB = 1;
	localparam logic [1:0] PCR_IMASK_RST = 2'h0;
	typedef enum logic [2:0] {
		PCR_OP_NONE, PCR_OP_LIST212, PCR_OP_LISTT1, PCR_OP_EXCH, PCR_OP_DESEL, PCR_OP_REL
	} pcr_op_t;
endpackage : pcr_pkg

// file: include/pcr_link_if.sv
// byte-stream link between host controller and reader command interpreter
`timescale 1ns/1ps
interface pcr_link_if;
	logic cmd_valid;
	logic cmd_ready;
	logic [7:0] cmd_data;
	logic cmd_last;
	logic rsp_valid;
	logic rsp_ready;
	logic [7:0] rsp_data;
	logic rsp_last;
	modport dev (input cmd_valid, cmd_data, cmd_last, rsp_ready,
		output cmd_ready, rsp_valid, rsp_data, rsp_last);
	modport host (output cmd_valid, cmd_data, cmd_last, rsp_ready,
		input cmd_ready, rsp_valid, rsp_data, rsp_last);
endinterface : pcr_link_if

// file: core/pcr_host_ctl.sv
// host controller: apb registers turned into command frames for the reader
`timescale 1ns/1ps
module pcr_host_ctl import pcr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	pcr_link_if.host l
);
	typedef enum logic [1:0] {H_IDLE, H_HDR, H_PAY, H_RSP} pcr_hst_t;

	pcr_hst_t st_q, st_d;
	logic [7:0] hdr_q [8];
	logic [7:0] hdr_d [8];
	logic [2:0] hn_q, hn_d, hi_q, hi_d;
	logic exch_q, exch_d;
	logic [7:0] tx_q, tx_d, rx_q, rx_d;
	logic txf_q, txf_d, txl_q, txl_d, rxf_q, rxf_d, rxl_q, rxl_d;
	logic [1:0] ist_q, ist_d, imsk_q, imsk_d;
	logic rdy_q, rdy_d, irq_q, irq_d, cv_q, cv_d, cl_q, cl_d, rr_q, rr_d;
	logic [31:0] rd_q, rd_d;
	logic [7:0] cd_q, cd_d;
	logic acc, wr, rd, cgo, rgo;
	logic [1:0] ev;
	pcr_op_t op;

	assign acc = psel & penable & rdy_q;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign cgo = cv_q & l.cmd_ready;
	assign rgo = l.rsp_valid & rr_q;
	assign op = pcr_op_t'(pwdata[2:0]);

	// ----------------------------------------
	// frame builder and registers
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		hdr_d = hdr_q;
		hn_d = hn_q;
		hi_d = hi_q;
		exch_d = exch_q;
		tx_d = tx_q;
		txf_d = txf_q;
		txl_d = txl_q;
		rx_d = rx_q;
		rxf_d = rxf_q;
		rxl_d = rxl_q;
		imsk_d = imsk_q;
		ev = 2'h0;
		if (wr && paddr == PCR_REG_CTRL && st_q == H_IDLE) begin
			// one command in flight; next waits for the whole answer
			hi_d = 3'h0;
			exch_d = (op == PCR_OP_EXCH);
			hdr_d[1] = PCR_MAX_TG;
			hdr_d[2] = PCR_BAUD_212;
			hdr_d[3] = PCR_POLL_CMD;
			hdr_d[4] = PCR_POLL_SYS;
			hdr_d[5] = PCR_POLL_SYS;
			hdr_d[6] = PCR_POLL_RC;
			hdr_d[7] = pwdata[15:8];
			st_d = H_HDR;
			case (op)
				PCR_OP_LIST212: begin
					hdr_d[0] = PCR_CMD_LIST;
					hn_d = 3'h7;
				end
				PCR_OP_LISTT1: begin
					hdr_d[0] = PCR_CMD_LIST;
					hdr_d[2] = PCR_BAUD_T1;
					hn_d = 3'h2;
				end
				PCR_OP_EXCH: begin
					hdr_d[0] = PCR_CMD_EXCH;
					hdr_d[1] = PCR_TARGET_ONE;
					hn_d = 3'h1;
				end
				PCR_OP_DESEL: begin
					hdr_d[0] = PCR_CMD_DESEL;
					hdr_d[1] = PCR_TARGET_ONE;
					hn_d = 3'h1;
				end
				PCR_OP_REL: begin
					hdr_d[0] = PCR_CMD_REL;
					hdr_d[1] = PCR_TARGET_ONE;
					hn_d = 3'h1;
				end
				default: st_d = H_IDLE;
			endcase
		end
		// card command bytes, length byte first, come from software
		if (wr && paddr == PCR_REG_TXDATA && !txf_q) begin
			tx_d = pwdata[7:0];
			txl_d = pwdata[PCR_TX_LAST_BIT];
			txf_d = 1'b1;
		end
		if (wr && paddr == PCR_REG_IMASK) imsk_d = pwdata[1:0];
		if (rd && paddr == PCR_REG_RXDATA) rxf_d = 1'b0;
		case (st_q)
			H_HDR: begin
				if (cgo) begin
					hi_d = 3'(hi_q + 3'h1);
					if (hi_q == hn_q) st_d = exch_q ? H_PAY : H_RSP;
				end
			end
			H_PAY: begin
				if (cgo) begin
					txf_d = 1'b0;
					if (txl_q) st_d = H_RSP;
				end
			end
			H_RSP: begin
				if (rgo && l.rsp_last) begin
					st_d = H_IDLE;
					ev[PCR_IRQ_DONE] = 1'b1;
				end
			end
			default: ;
		endcase
		if (rgo) begin
			rx_d = l.rsp_data;
			rxl_d = l.rsp_last;
			rxf_d = 1'b1;
			ev[PCR_IRQ_RXB] = 1'b1;
		end
		// an event in the clearing cycle survives
		ist_d = (ist_q & ~((wr && paddr == PCR_REG_ISTAT) ? pwdata[1:0] : 2'h0)) | ev;
		irq_d = |(ist_d & imsk_d);
		cv_d = (st_d == H_HDR) || (st_d == H_PAY && txf_d);
		cd_d = (st_d == H_HDR) ? hdr_d[hi_d] : tx_d;
		cl_d = (st_d == H_HDR) ? (hi_d == hn_d && !exch_d) : txl_d;
		rr_d = !rxf_d;
		rdy_d = psel & penable & ~rdy_q;
		case (paddr)
			PCR_REG_RXDATA: rd_d = {23'h0, rxl_q, rx_q};
			PCR_REG_STATUS: rd_d = {28'h0, rxl_q, rxf_q, txf_q, st_q != H_IDLE};
			PCR_REG_ISTAT: rd_d = {30'h0, ist_q};
			PCR_REG_IMASK: rd_d = {30'h0, imsk_q};
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= H_IDLE;
			hdr_q <= '{default: 8'h00};
			hn_q <= 3'h0;
			hi_q <= 3'h0;
			exch_q <= 1'b0;
			tx_q <= 8'h00;
			txf_q <= 1'b0;
			txl_q <= 1'b0;
			rx_q <= 8'h00;
			rxf_q <= 1'b0;
			rxl_q <= 1'b0;
			ist_q <= 2'h0;
			imsk_q <= PCR_IMASK_RST;
			irq_q <= 1'b0;
			cv_q <= 1'b0;
			cd_q <= 8'h00;
			cl_q <= 1'b0;
			rr_q <= 1'b0;
			rdy_q <= 1'b0;
			rd_q <= 32'h0;
		end else begin
			st_q <= st_d;
			hdr_q <= hdr_d;
			hn_q <= hn_d;
			hi_q <= hi_d;
			exch_q <= exch_d;
			tx_q <= tx_d;
			txf_q <= txf_d;
			txl_q <= txl_d;
			rx_q <= rx_d;
			rxf_q <= rxf_d;
			rxl_q <= rxl_d;
			ist_q <= ist_d;
			imsk_q <= imsk_d;
			irq_q <= irq_d;
			cv_q <= cv_d;
			cd_q <= cd_d;
			cl_q <= cl_d;
			rr_q <= rr_d;
			rdy_q <= rdy_d;
			if (rdy_d) rd_q <= rd_d;
		end
	end

	assign prdata = rd_q;
	assign pready = rdy_q;
	assign pslverr = 1'b0;
	assign irq = irq_q;
	assign l.cmd_valid = cv_q;
	assign l.cmd_data = cd_q;
	assign l.cmd_last = cl_q;
	assign l.rsp_ready = rr_q;
endmodule : pcr_host_ctl

// file: sim/pcr_link_props.sv
// assertions on the command link between host controller and reader interpreter
`timescale 1ns/1ps
module pcr_link_props import pcr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_last,
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_last
);
	// ----------------------------------------
	// frame tracking
	// ----------------------------------------
	logic [7:0] cmd_idx_q, cmd_idx_d, rsp_idx_q, rsp_idx_d, code_q, code_d;
	logic pend_q, pend_d;
	wire cmd_take = cmd_valid && cmd_ready;
	wire rsp_take = rsp_valid && rsp_ready;
	always_comb begin
		cmd_idx_d = cmd_take ? (cmd_last ? 8'h00 : cmd_idx_q + 8'h01) : cmd_idx_q;
		rsp_idx_d = rsp_take ? (rsp_last ? 8'h00 : rsp_idx_q + 8'h01) : rsp_idx_q;
		code_d = (cmd_take && cmd_idx_q == 8'h00) ? cmd_data : code_q;
		pend_d = (cmd_take && cmd_last) ? 1'b1 : ((rsp_take && rsp_last) ? 1'b0 : pend_q);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_idx_q <= 8'h00;
			rsp_idx_q <= 8'h00;
			code_q <= 8'h00;
			pend_q <= 1'b0;
		end else begin
			cmd_idx_q <= cmd_idx_d;
			rsp_idx_q <= rsp_idx_d;
			code_q <= code_d;
			pend_q <= pend_d;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cmd_end;
		cmd_take && cmd_last;
	endsequence
	sequence s_rsp_head(logic [7:0] c);
		rsp_valid && rsp_idx_q == 8'h00 && code_q == c;
	endsequence
	AST_CMD_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data) && $stable(cmd_last))
		else $error("command byte changed before taken");
	AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last))
		else $error("response byte changed before taken");
	AST_REFUSE_BUSY: assert property (pend_q |-> !cmd_ready)
		else $error("command accepted before response finished");
	AST_RSP_NEEDS_CMD: assert property (rsp_valid |-> pend_q)
		else $error("response without a command");
	AST_LIST_CODE: assert property (s_rsp_head(PCR_CMD_LIST) |-> rsp_data == PCR_RSP_LIST && !rsp_last)
		else $error("wrong list response code");
	AST_LIST_COUNT: assert property (rsp_valid && rsp_idx_q == 8'h01 && code_q == PCR_CMD_LIST |->
		(rsp_data == PCR_ONE_FOUND && !rsp_last) || (rsp_data == PCR_NONE_FOUND && rsp_last))
		else $error("wrong list target count");
	AST_EXCH_CODE: assert property (s_rsp_head(PCR_CMD_EXCH) |-> rsp_data == PCR_RSP_EXCH && !rsp_last)
		else $error("wrong exchange response code");
	AST_DEREL_CODE: assert property (rsp_valid && rsp_idx_q == 8'h00 && (code_q == PCR_CMD_DESEL ||
		code_q == PCR_CMD_REL) |-> rsp_data == code_q + 8'h01)
		else $error("wrong deselect or release code");
	AST_DEREL_STATUS: assert property (rsp_valid && rsp_idx_q == 8'h01 && (code_q == PCR_CMD_DESEL ||
		code_q == PCR_CMD_REL) |-> rsp_data == PCR_ST_OK && rsp_last)
		else $error("deselect or release status not ok");
	AST_DESEL_FAST: assert property (s_cmd_end ##0 code_q == PCR_CMD_DESEL |-> ##[1:40] rsp_valid)
		else $error("deselect answer late");
	AST_EXCH_TARGET: assert property (cmd_valid && cmd_idx_q == 8'h01 && code_q == PCR_CMD_EXCH |->
		cmd_data == PCR_TARGET_ONE)
		else $error("exchange not sent to target one");
	AST_LIST_MAXTG: assert property (cmd_valid && cmd_idx_q == 8'h01 && code_q == PCR_CMD_LIST |->
		cmd_data == PCR_MAX_TG && !cmd_last)
		else $error("list target count not one");
endmodule : pcr_link_props

// file: sim/tb_top.sv
// self-checking bench: apb host controller and reader interpreter joined by the link
`timescale 1ns/1ps
module tb_top import pcr_pkg::*;;
	// ----------------------------------------
	// setup
	// ----------------------------------------
	localparam int unsigned ACT_B = 20;
	localparam int unsigned ACT_S = 10;
	localparam int unsigned EXCH_T = 50;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, target_active, frame_done;
	logic card_tx_valid, card_tx_ready, card_tx_last, card_rx_valid, card_rx_ready, card_rx_last;
	logic [7:0] paddr, card_tx_data, card_rx_data, retry_lim, time_slot_number;
	logic [31:0] pwdata, prdata, exch_to, rd;
	logic [7:0] txb[$], exp_q[$], rep[$], txq[$], pq[$];
	logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h1a, 8'h1c, 8'h53, 8'h55};
	int n_errors = 0, check_count = 0, cyc = 0, t_poll = 0, t_rsp = 0, seed, n;
	pcr_link_if link();
	pcr_host_ctl pcr_host_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .l(link));
	pcr_reader_dev #(.ACT_BASE_CYC(ACT_B), .ACT_SLOT_CYC(ACT_S), .EXCH_TO_CYC(EXCH_T))
		pcr_reader_dev_inst (.pclk(pclk), .presetn(presetn), .l(link), .card_tx_valid(card_tx_valid),
		.card_tx_ready(card_tx_ready), .card_tx_data(card_tx_data), .card_tx_last(card_tx_last),
		.card_rx_valid(card_rx_valid), .card_rx_ready(card_rx_ready), .card_rx_data(card_rx_data),
		.card_rx_last(card_rx_last), .activation_retry_limit(retry_lim), .exch_timeout(exch_to),
		.target_active(target_active));
	pcr_link_props pcr_link_props_inst (.pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
		.rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data),
		.rsp_last(link.rsp_last));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// card side: random stalls on the transmit path, stamps for the timeout windows
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		card_tx_ready <= 1'($urandom_range(1));
		if (card_tx_valid && card_tx_ready) begin
			txq.push_back(card_tx_data);
			if (card_tx_last) begin
				frame_done <= 1'b1;
				t_poll <= cyc;
			end
		end
		if (link.rsp_valid && t_rsp == 0) t_rsp <= cyc;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic poll(input int b, input logic v);
		do apb(1'b0, PCR_REG_STATUS, 32'h0); while (rd[b] !== v);
	endtask : poll
	function automatic logic [7:0] rb();
		return 8'($urandom_range(255));
	endfunction : rb
	function automatic void set_exp(input logic [7:0] a, input logic [7:0] b, input logic c,
		input logic with_rep);
		exp_q = {a, b};
		if (c) exp_q.push_back(PCR_TARGET_ONE);
		if (with_rep) foreach (rep[i]) exp_q.push_back(rep[i]);
	endfunction : set_exp
	function automatic logic in_win(input int w);
		return (t_rsp - t_poll >= w) && (t_rsp - t_poll <= w + 16);
	endfunction : in_win
	task automatic card_reply();
		while (frame_done !== 1'b1) @(posedge pclk);
		foreach (rep[i]) begin
			card_rx_valid <= 1'b1;
			card_rx_data <= rep[i];
			card_rx_last <= (i == rep.size() - 1);
			do @(posedge pclk); while (card_rx_ready !== 1'b1);
		end
		card_rx_valid <= 1'b0;
		card_rx_data <= ~card_rx_data;
	endtask : card_reply
	task automatic get_rsp();
		foreach (exp_q[i]) begin
			poll(2, 1'b1);
			apb(1'b0, PCR_REG_RXDATA, 32'h0);
			chk(rd[8:0], {i == exp_q.size() - 1, exp_q[i]});
		end
	endtask : get_rsp
	task automatic run(input logic [2:0] op, input logic [7:0] ts, input logic reply);
		poll(0, 1'b0);
		txq.delete();
		frame_done = 1'b0;
		t_rsp = 0;
		apb(1'b1, PCR_REG_CTRL, {16'h0, ts, 5'h0, op});
		foreach (txb[i]) begin
			poll(1, 1'b0);
			apb(1'b1, PCR_REG_TXDATA, {23'h0, i == txb.size() - 1, txb[i]});
		end
		fork
			if (reply) card_reply();
			get_rsp();
		join
		poll(0, 1'b0);
	endtask : run
	task automatic chk_tx();
		chk(txq.size(), pq.size());
		foreach (pq[i]) chk(txq[i], pq[i]);
	endtask : chk_tx
	task automatic results();
		$display("checks=%0d errors=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	initial begin
		repeat (40000) @(posedge pclk);
		n_errors++;
		results();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, card_rx_valid, card_rx_last, card_tx_ready, frame_done} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		card_rx_data = 8'h00;
		exch_to = 32'h0;
		retry_lim = PCR_RETRY_FOREVER;
		seed = $urandom(32'he979c21f);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({pready, pslverr, irq, target_active}, 32'h0);
		apb(1'b1, PCR_REG_IMASK, 32'h3);
		// listing at 212 with a card answering
		time_slot_number = 8'($urandom_range(3));
		pq = {PCR_POLL_CMD, PCR_POLL_SYS, PCR_POLL_SYS, PCR_POLL_RC, time_slot_number};
		rep = {rb(), rb(), rb()};
		set_exp(PCR_RSP_LIST, PCR_ONE_FOUND, 1'b1, 1'b1);
		run(3'h1, time_slot_number, 1'b1);
		chk_tx();
		chk({target_active, irq}, 32'h3);
		apb(1'b1, PCR_REG_ISTAT, 32'h3);
		apb(1'b0, PCR_REG_ISTAT, 32'h0);
		chk({rd[1:0], irq}, 32'h0);
		apb(1'b1, PCR_REG_IMASK, 32'h0);
		// exchange carrying a full card command; events now masked
		n = $urandom_range(4);
		txb = {8'(n + 2), rb()};
		repeat (n) txb.push_back(rb());
		pq = txb;
		rep = {rb(), rb()};
		set_exp(PCR_RSP_EXCH, PCR_ST_OK, 1'b0, 1'b1);
		run(3'h3, 8'h00, 1'b1);
		chk_tx();
		apb(1'b0, PCR_REG_ISTAT, 32'h0);
		chk({irq, rd[1:0]}, 32'h3);
		// second listing while a target is held
		txb.delete();
		set_exp(PCR_RSP_LIST, PCR_NONE_FOUND, 1'b0, 1'b0);
		run(3'h1, 8'h00, 1'b0);
		set_exp(PCR_CMD_DESEL + 8'h01, PCR_ST_OK, 1'b0, 1'b0);
		run(3'h4, 8'h00, 1'b0);
		chk(txq.size() + target_active, 32'h0);
		txb = {8'h02};
		set_exp(PCR_RSP_EXCH, PCR_ST_ERR, 1'b0, 1'b0);
		run(3'h3, 8'h00, 1'b0);
		// empty field: one retry at the widest slot count
		retry_lim <= 8'h02;
		txb.delete();
		pq = {PCR_POLL_CMD, PCR_POLL_SYS, PCR_POLL_SYS, PCR_POLL_RC, 8'hff};
		pq = {pq, pq};
		set_exp(PCR_RSP_LIST, PCR_NONE_FOUND, 1'b0, 1'b0);
		run(3'h1, 8'hff, 1'b0);
		chk_tx();
		chk(in_win(ACT_B + 256 * ACT_S), 32'h1);
		retry_lim <= 8'h01;
		pq = {PCR_BAUD_T1};
		run(3'h2, 8'h00, 1'b0);
		chk_tx();
		// type-1 tag listed, then every tag command
		retry_lim <= PCR_RETRY_FOREVER;
		rep = {8'h04, 8'h00, rb(), rb(), rb(), rb()};
		set_exp(PCR_RSP_LIST, PCR_ONE_FOUND, 1'b1, 1'b1);
		run(3'h2, 8'h00, 1'b1);
		chk_tx();
		foreach (codes[i]) begin
			txb = {codes[i], rb()};
			pq = txb;
			rep = {rb()};
			set_exp(PCR_RSP_EXCH, PCR_ST_OK, 1'b0, 1'b1);
			run(3'h3, 8'h00, 1'b1);
			chk_tx();
		end
		// silent card: exchange ends on the default timeout
		set_exp(PCR_RSP_EXCH, PCR_ST_ERR, 1'b0, 1'b0);
		run(3'h3, 8'h00, 1'b0);
		chk(in_win(EXCH_T), 32'h1);
		// override shortens the wait
		exch_to <= 32'h28;
		run(3'h3, 8'h00, 1'b0);
		chk(in_win(40), 32'h1);
		txb.delete();
		set_exp(PCR_CMD_REL + 8'h01, PCR_ST_OK, 1'b0, 1'b0);
		run(3'h5, 8'h00, 1'b0);
		chk(txq.size() + target_active, 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		chk(rd, 32'h0);
		results();
	end
endmodule : tb_top
